// [bench/pad_line.sv]
// Board-side model of the port pads and outside sources
`timescale 1ns/100ps
module pad_line (
  input wire logic sys_clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  // Undriven pins with no pull-up wander every cycle
  logic [7:0] float_r = 8'h5A;
  // Flip the wandering pattern
  always @(posedge sys_clk) float_r <= ~float_r;
  // Own driver first, then the outside source, then the pull-up
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drv & ext_val)
    | (pad_oe_n & ~ext_drv & (pullup_en | float_r));
endmodule : pad_line

// [bench/port_pin_input_override_bench.sv]
// Self-checking bench for the port pin block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module port_pin_input_override_bench;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, pad_in, pad_out, pad_oe_n, pullup_en, input_en;
  logic [7:0] ext_int_en, ext_int_edge_cfg, ext_int_flag_set, alt_fn_input;
  logic [7:0] uo_e, uo_v, do_e, do_v, vo_e, vo_v, io_e, io_v, ext_drv, ext_val;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0] sleep_mode;
  // Reference model state of the registers
  int mismatches, checks, out_m, dir_m, gpd_m;
  int modes[$] = '{0, 1, 2, 3, 4, 5, 6, 7};
  logic [7:0] regs[3] = '{port_pkg::OFS_OUT, port_pkg::OFS_DIR,
    port_pkg::OFS_CTRL};

  port_pin_top DUT (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
    .input_en(input_en), .sleep_mode(sleep_mode), .ext_int_en(ext_int_en),
    .ext_int_edge_cfg(ext_int_edge_cfg),
    .ext_int_flag_set(ext_int_flag_set),
    .pullup_override_en(uo_e), .pullup_override_val(uo_v),
    .direction_override_en(do_e), .direction_override_val(do_v),
    .port_value_override_en(vo_e), .port_value_override_val(vo_v),
    .input_enable_override_en(io_e), .input_enable_override_val(io_v),
    .alt_fn_input(alt_fn_input)
  );
  pad_line pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pullup_en(pullup_en), .ext_drv(ext_drv), .ext_val(ext_val),
    .pad_in(pad_in));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // One APB transfer, result left in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Compare pad controls with the reference model
  task automatic check_pins();
    logic [7:0] dr, pu, ie, cl;
    @(negedge sys_clk);
    cl = (sleep_mode inside {3'h3, 3'h4, 3'h6, 3'h7}) ? 8'h00 : 8'hFF;
    dr = (do_e & do_v) | (~do_e & dir_m[7:0]);
    pu = (uo_e & uo_v) | (~uo_e & ~dir_m[7:0] & out_m[7:0] & {8{gpd_m == 0}});
    ie = (io_e & io_v) | (~io_e & (cl | ext_int_en));
    `CHK(pad_oe_n, ~dr)
    `CHK(pullup_en, pu)
    `CHK(pad_out & dr, ((vo_e & vo_v) | (~vo_e & out_m[7:0])) & dr)
    `CHK(input_en, ie)
    `CHK(alt_fn_input, pad_in & ie)
  endtask : check_pins

  // Write the three registers and the model together
  task automatic set_regs(input int o, input int d, input int g);
    out_m = o;
    dir_m = d;
    gpd_m = g;
    apb(1'b1, port_pkg::OFS_OUT, out_m);
    apb(1'b1, port_pkg::OFS_DIR, dir_m);
    apb(1'b1, port_pkg::OFS_CTRL, gpd_m);
  endtask : set_regs

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Hang guard, well past the few hundred cycles needed
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    seed = 32'h341F3213;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_mode, ext_int_en, ext_int_edge_cfg, ext_drv, ext_val} = '0;
    {uo_e, uo_v, do_e, do_v, vo_e, vo_v, io_e, io_v} = 64'hFFFFFFFFFFFFFFFF;
    repeat (2) @(posedge sys_clk);
    // Overrides held active must not reach the pads in reset
    @(negedge sys_clk);
    `CHK(pad_oe_n, 8'hFF)
    `CHK(pullup_en, 8'h00)
    @(posedge sys_clk);
    nrst <= 1'b1;
    {uo_e, uo_v, do_e, do_v, vo_e, vo_v, io_e, io_v} <= '0;
    foreach (regs[k])
    begin
      apb(1'b0, regs[k], 32'h0);
      `CHK(rd, 32'h0)
    end
    $display("reset test done");
    // Random registers, overrides and sleep codes
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      set_regs(seed[7:0], seed[15:8], seed[16]);
      seed = lfsr(seed);
      {uo_e, uo_v, do_e, do_v} <= seed;
      seed = lfsr(seed);
      {vo_e, vo_v, io_e, io_v} <= seed;
      ext_int_en <= seed[7:0] ^ seed[31:24];
      sleep_mode <= 3'(modes[i % 8]);
      check_pins();
      apb(1'b0, port_pkg::OFS_OUT, 32'h0);
      `CHK(rd, 32'(out_m))
      apb(1'b0, port_pkg::OFS_DIR, 32'h0);
      `CHK({err, rd}, {1'b0, 32'(dir_m)})
    end
    $display("random test done");
    // Unmapped place refused, input register not writable
    apb(1'b1, 8'h10, 32'hFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, port_pkg::OFS_PIN, 32'hFF);
    apb(1'b0, port_pkg::OFS_OUT, 32'h0);
    `CHK({err, rd}, {1'b0, 32'(out_m)})
    $display("refusal test done");
    // Mixed drive: low nibble from the port, high nibble from outside
    {uo_e, uo_v, do_e, do_v, vo_e, vo_v, io_e, io_v} <= '0;
    sleep_mode <= 3'h0;
    ext_drv <= 8'hF0;
    ext_val <= 8'h6C;
    set_regs(8'hA5, 8'h0F, 1);
    apb(1'b0, port_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, port_pkg::OFS_PIN, 32'h0);
    `CHK(rd, 32'h65)
    ext_val <= 8'h93;
    apb(1'b0, port_pkg::OFS_PIN, 32'h0);
    `CHK(rd, 32'h95)
    check_pins();
    $display("sync test done");
    // Deep sleep with mixed interrupt setup, then wake
    set_regs(8'h00, 8'h00, 1);
    seed = lfsr(seed);
    ext_drv <= 8'hFF;
    ext_val <= 8'hFF;
    ext_int_edge_cfg <= seed[7:0];
    ext_int_en <= seed[15:8];
    sleep_mode <= 3'h3;
    check_pins();
    apb(1'b0, port_pkg::OFS_PIN, 32'h0);
    `CHK(rd, {24'h0, seed[15:8]})
    @(posedge sys_clk);
    sleep_mode <= 3'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ext_int_flag_set, seed[7:0] & ~seed[15:8])
    @(negedge sys_clk);
    `CHK(ext_int_flag_set, 8'h00)
    $display("sleep test done");
    wrap_up();
  end
endmodule : port_pin_input_override_bench

// [common/port_pkg.sv]
// Constants, register map and sleep codes for the port pin block
//
// Behaviour
// - Pin input bit readable regardless of direction
// - Latch open on clock high, flop loads
// - Pad edge appears within half to 1.5 periods
// - Software write sets latch at write edge
// - Deep sleep clamps digital input to ground
// - Enabled external interrupt lifts the sleep clamp
// - High clamped edge interrupt pin flags on wake
// - Pull-ups are off during reset
// - Pull-up follows override or dir/out/disable 010
// - Driver enable follows override or direction bit
// - Driven value follows override or output bit
// - Input enable follows override or sleep state
// - Alternate input taken before the synchronizer
// - Analog line goes straight to the pad
// - Strobes per port, clock/sleep/disable shared
// - Peripherals drive overrides, others tie inactive
// - Direction one is output, zero is input
// - Pins tri-state as soon as reset asserts
// - Global pull-up disable turns off all pull-ups not set by override
package port_pkg;
  // Pins per port
  localparam int PORT_WIDTH = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_OUT = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PIN = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  // Control register field position
  localparam int CTRL_GPD_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic RST_GPD = 1'b0;
  // Sleep controller mode codes
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h0,
    MODE_IDLE = 3'h1,
    MODE_ADC_NR = 3'h2,
    MODE_PWR_DOWN = 3'h3,
    MODE_PWR_SAVE = 3'h4,
    MODE_STANDBY = 3'h6,
    MODE_EXT_STANDBY = 3'h7
  } sleep_mode_t;
  // Wake tracker states, one-hot
  typedef enum logic [1:0] {
    ST_AWAKE = 2'h1,
    ST_CLAMPED = 2'h2
  } wake_st_t;
endpackage : port_pkg

// [common/sync_if.sv]
// Carrier between the port top and its pin synchronizer
`timescale 1ns/100ps
interface sync_if #(parameter int W = 8);
  logic [W-1:0] sample_d; // Level offered to the latch
  logic [W-1:0] sync_q; // Synchronized level
  modport src (output sample_d, input sync_q);
  modport snk (input sample_d, output sync_q);
endinterface : sync_if

// [rtl/pin_sync.sv]
// Latch plus flop pin synchronizer, one bit per pin
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  sync_if.snk link
);
  logic [W-1:0] lat; // Clock-high transparent latch

  // Latch open while clock high, holds while low
  always_latch
  begin
    if (sys_clk)
      lat <= link.sample_d;
  end

  // Held value loaded at the next rising edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      link.sync_q <= '0;
    else
      link.sync_q <= lat;
  end
endmodule : pin_sync

// [rtl/port_pin_top.sv]
// One GPIO port: APB registers, override path, sleep clamp, synchronizer
`timescale 1ns/100ps
module port_pin_top #(
  parameter int W = port_pkg::PORT_WIDTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pullup_en,
  output logic [W-1:0] input_en,
  // Sleep controller and external interrupt unit
  input wire logic [2:0] sleep_mode,
  input wire logic [W-1:0] ext_int_en,
  input wire logic [W-1:0] ext_int_edge_cfg,
  output logic [W-1:0] ext_int_flag_set,
  // Peripheral overrides
  input wire logic [W-1:0] pullup_override_en,
  input wire logic [W-1:0] pullup_override_val,
  input wire logic [W-1:0] direction_override_en,
  input wire logic [W-1:0] direction_override_val,
  input wire logic [W-1:0] port_value_override_en,
  input wire logic [W-1:0] port_value_override_val,
  input wire logic [W-1:0] input_enable_override_en,
  input wire logic [W-1:0] input_enable_override_val,
  output logic [W-1:0] alt_fn_input
);
  logic [W-1:0] output_value_bit_r; // Output value per pin
  logic [W-1:0] direction_bit_r; // Direction per pin
  logic global_pullup_disable_r; // Shared pull-up disable
  logic [W-1:0] pin_input_bit; // Synchronized pin level
  logic [W-1:0] raw_level; // Synchronized unclamped pad level
  logic [W-1:0] pu_oe; // Gated pull-up override enables
  logic [W-1:0] dd_oe; // Gated direction override enables
  logic [W-1:0] pv_oe; // Gated value override enables
  logic [W-1:0] ie_oe; // Gated input-enable override enables
  logic [W-1:0] drive_en; // Output driver enabled
  logic [W-1:0] readback_mask; // Pins latching their own output bit
  logic [W-1:0] schmitt; // Clamped digital input
  logic clamp_mode; // Sleep mode that clamps inputs
  logic [W-1:0] keep_on; // Interrupt pins kept alive
  logic [31:0] prdata_r; // Registered read data
  logic pslverr_r; // Registered error answer
  logic setup; // APB setup phase
  logic wr_acc; // APB write taking effect
  logic hit; // Address maps a register
  logic [W-1:0] seen_high_r; // Pad high while clamped
  logic [W-1:0] flag_set_r; // Wake flag pulse
  port_pkg::wake_st_t st_r; // Wake tracker state
  port_pkg::wake_st_t st_nxt; // Next tracker state

  sync_if #(.W(W)) pin_link ();
  sync_if #(.W(W)) raw_link ();

  // Override enables forced off while in reset
  // Pins without a peripheral get zeros at top level
  assign pu_oe = pullup_override_en & {W{nrst}};
  assign dd_oe = direction_override_en & {W{nrst}};
  assign pv_oe = port_value_override_en & {W{nrst}};
  assign ie_oe = input_enable_override_en & {W{nrst}};

  // Clamping sleep modes
  always_comb
  begin
    case (sleep_mode)
      port_pkg::MODE_PWR_DOWN,
      port_pkg::MODE_PWR_SAVE,
      port_pkg::MODE_STANDBY,
      port_pkg::MODE_EXT_STANDBY: clamp_mode = 1'b1;
      default: clamp_mode = 1'b0;
    endcase
  end

  // Enabled external interrupts keep their input alive
  assign keep_on = ext_int_en;

  // Input enable: override first, else sleep state
  assign input_en = (ie_oe & input_enable_override_val)
    | (~ie_oe & (~{W{clamp_mode}} | keep_on));

  // Driver enable from override or direction bit
  assign drive_en = (dd_oe & direction_override_val)
    | (~dd_oe & direction_bit_r);

  // Active-low enable, released at once in reset
  assign pad_oe_n = ~(drive_en & {W{nrst}});

  // Driven value from override or output bit
  assign pad_out = (pv_oe & port_value_override_val)
    | (~pv_oe & output_value_bit_r);

  // Driven, unoverridden, enabled pins echo the output bit
  assign readback_mask = drive_en & ~pv_oe & input_en;

  // Pull-up: override, else dir/out/disable 010, off in reset
  assign pullup_en = {W{nrst}} & ((pu_oe & pullup_override_val)
    | (~pu_oe & ~direction_bit_r & output_value_bit_r
    & {W{~global_pullup_disable_r}}));

  // Schmitt output: driven value when driving, else pad, then clamp
  // so a software write reaches the latch at its own edge
  assign schmitt = ((drive_en & pad_out) | (~drive_en & pad_in))
    & input_en;

  // Alternate functions see the input ahead of the synchronizer
  assign alt_fn_input = schmitt;

  // The analog line is wired pad to peripheral outside this logic;
  // no digital cell sits in its path

  // Synchronizer feeding the readable pin bits
  assign pin_link.sample_d = schmitt;
  assign pin_input_bit = pin_link.sync_q;
  pin_sync #(.W(W)) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .link(pin_link)
  );

  // Second synchronizer on the unclamped pad for wake detection
  assign raw_link.sample_d = pad_in;
  assign raw_level = raw_link.sync_q;
  pin_sync #(.W(W)) u_raw_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .link(raw_link)
  );

  // APB decode; one strobe serves every pin of the port
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & ~pslverr_r;
  assign hit = (paddr == port_pkg::OFS_OUT) | (paddr == port_pkg::OFS_DIR)
    | (paddr == port_pkg::OFS_PIN) | (paddr == port_pkg::OFS_CTRL);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Output value register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      output_value_bit_r <= port_pkg::RST_OUT[W-1:0];
    else if (wr_acc && paddr == port_pkg::OFS_OUT)
      output_value_bit_r <= pwdata[W-1:0];
  end

  // Direction register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      direction_bit_r <= port_pkg::RST_DIR[W-1:0];
    else if (wr_acc && paddr == port_pkg::OFS_DIR)
      direction_bit_r <= pwdata[W-1:0];
  end

  // Shared pull-up disable bit
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      global_pullup_disable_r <= port_pkg::RST_GPD;
    else if (wr_acc && paddr == port_pkg::OFS_CTRL)
      global_pullup_disable_r <= pwdata[port_pkg::CTRL_GPD_BIT];
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= ~hit;
      prdata_r <= 32'h0000_0000;
      // Pin bits read in any direction
      case (paddr)
        port_pkg::OFS_OUT: prdata_r[W-1:0] <= output_value_bit_r;
        port_pkg::OFS_DIR: prdata_r[W-1:0] <= direction_bit_r;
        port_pkg::OFS_PIN: prdata_r[W-1:0] <= pin_input_bit;
        port_pkg::OFS_CTRL:
          prdata_r[port_pkg::CTRL_GPD_BIT] <= global_pullup_disable_r;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Wake tracker next state
  always_comb
  begin
    case (st_r)
      port_pkg::ST_AWAKE:
        st_nxt = clamp_mode ? port_pkg::ST_CLAMPED : port_pkg::ST_AWAKE;
      port_pkg::ST_CLAMPED:
        st_nxt = clamp_mode ? port_pkg::ST_CLAMPED : port_pkg::ST_AWAKE;
      default: st_nxt = port_pkg::ST_AWAKE;
    endcase
  end

  // Wake tracker state
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      st_r <= port_pkg::ST_AWAKE;
    else
      st_r <= st_nxt;
  end

  // Record edge-configured, disabled interrupt pins high while clamped
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      seen_high_r <= '0;
    else if (st_r == port_pkg::ST_CLAMPED && st_nxt == port_pkg::ST_AWAKE)
      seen_high_r <= '0;
    else if (st_r == port_pkg::ST_CLAMPED)
      seen_high_r <= seen_high_r
        | (raw_level & ext_int_edge_cfg & ~ext_int_en);
  end

  // One-cycle flag set pulse on leaving the clamp
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      flag_set_r <= '0;
    else if (st_r == port_pkg::ST_CLAMPED && st_nxt == port_pkg::ST_AWAKE)
      flag_set_r <= seen_high_r
        | (raw_level & ext_int_edge_cfg & ~ext_int_en);
    else
      flag_set_r <= '0;
  end
  assign ext_int_flag_set = flag_set_r;

  // Checks
  property p_reset_tristate;
    @(posedge sys_clk) !nrst |-> (pad_oe_n == {W{1'b1}});
  endproperty
  a_reset_tristate: assert property (p_reset_tristate)
    else $error("pins driven during reset");

  property p_reset_pullup;
    @(posedge sys_clk) !nrst |-> (pullup_en == '0);
  endproperty
  a_reset_pullup: assert property (p_reset_pullup)
    else $error("pull-up on during reset");

  property p_gpd_off;
    @(posedge sys_clk) disable iff (!nrst)
      (global_pullup_disable_r && pu_oe == '0) |-> (pullup_en == '0);
  endproperty
  a_gpd_off: assert property (p_gpd_off)
    else $error("pull-up on while globally disabled");

  property p_pullup_not_output;
    @(posedge sys_clk) disable iff (!nrst)
      (pu_oe == '0) |-> ((pullup_en & direction_bit_r) == '0);
  endproperty
  a_pullup_not_output: assert property (p_pullup_not_output)
    else $error("pull-up on an output pin");

  property p_clamp;
    @(posedge sys_clk) disable iff (!nrst)
      (clamp_mode && ie_oe == '0) |-> (input_en == ext_int_en);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("sleep clamp wrong");

  property p_drive_value;
    @(posedge sys_clk) disable iff (!nrst)
      (pv_oe == '0) |->
        (((pad_out ^ output_value_bit_r) & ~pad_oe_n) == '0);
  endproperty
  a_drive_value: assert property (p_drive_value)
    else $error("driven value differs from output bit");

  property p_readback;
    @(posedge sys_clk) disable iff (!nrst)
      (wr_acc && paddr == port_pkg::OFS_OUT)
      |-> ##2 (((pin_input_bit ^ $past(pwdata[W-1:0], 2))
        & $past(readback_mask, 2)) == '0);
  endproperty
  a_readback: assert property (p_readback)
    else $error("written value not read back after one period");

  property p_flag_pulse;
    @(posedge sys_clk) disable iff (!nrst)
      (flag_set_r != '0) |-> ($past(st_r) == port_pkg::ST_CLAMPED)
        ##1 (flag_set_r == '0);
  endproperty
  a_flag_pulse: assert property (p_flag_pulse)
    else $error("wake flag pulse wrong");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!nrst)
      (setup && !hit) |=> (pslverr && prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
endmodule : port_pin_top
